// ---- alarm_mask_offset_sync_regs.sv ----
/*
  alarm mask, per-channel offset correction with double buffering, and
  fifo read-pointer preset, reached over apb.
  assumes alarm sources, fifo sync and converter samples are synchronous to pclk;
  fifo_sync_evt is a one-cycle pulse from the same clock domain.
*/
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module alarm_mask_offset_sync_regs #(
  parameter int NCH = 4                                  // converter channels
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [15:0]           alarm_raw,          // alarm sources, level
  input  wire logic                  fifo_sync_evt,      // fifo sync pulse
  input  wire logic [NCH*16-1:0]     sample_in,          // samples per channel
  output logic      [NCH*16-1:0]     sample_out,         // samples or mid-scale
  output logic      [2:0]            fifo_rd_ptr,        // preset read pointer
  output logic      [12:0]           chan_a_dc_correction,
  output logic      [12:0]           chan_b_dc_correction,
  output logic      [12:0]           chan_c_dc_correction,
  output logic      [12:0]           chan_d_dc_correction,
  output logic                       alarm_combined,     // any unmasked used alarm
  output logic                       irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0]        mask_r,   mask_nxt;      // alarm source mask
  logic [15:0]        reg_a_r,  reg_a_nxt;     // channel A shadow
  logic [15:0]        reg_b_r,  reg_b_nxt;     // fifo preset + channel B shadow
  logic [15:0]        reg_c_r,  reg_c_nxt;     // channel C shadow
  logic [15:0]        reg_d_r,  reg_d_nxt;     // channel D shadow
  logic [12:0]        act_a_r,  act_a_nxt;     // active offsets
  logic [12:0]        act_b_r,  act_b_nxt;
  logic [12:0]        act_c_r,  act_c_nxt;
  logic [12:0]        act_d_r,  act_d_nxt;
  logic               sync_en_r, sync_en_nxt;  // auto-sync enable
  logic [15:0]        astat_r,  astat_nxt;     // sticky alarm status
  logic [2:0]         ptr_r,    ptr_nxt;       // fifo read pointer
  logic [3:0]         istat_r,  istat_nxt;     // sticky irq status
  logic [3:0]         imask_r,  imask_nxt;     // irq enables
  logic [31:0]        rdata_r,  rdata_nxt;
  logic               ready_r,  ready_nxt;
  logic               err_r,    err_nxt;
  logic               comb_r,   comb_nxt;
  logic               irq_r,    irq_nxt;
  logic [NCH*16-1:0]  samp_r,   samp_nxt;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic       acc;          // access phase, answered next cycle
  logic       wr;
  logic       rd;
  logic       hit;
  logic [15:0] wmask;       // byte-lane mask for the low halfword
  logic [15:0] unmasked;    // alarm sources that pass the mask

  // one wait state: pready rises one cycle after the first access edge
  assign acc   = psel & penable & ~ready_r;
  assign wr    = acc & pwrite;
  assign rd    = acc & ~pwrite;
  assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign unmasked = alarm_raw & ~mask_r & alarm_offset_pkg::ALARM_USED;

  always_comb begin
    case (paddr)
      alarm_offset_pkg::ADDR_ALARM_MASK,
      alarm_offset_pkg::ADDR_CHAN_A,
      alarm_offset_pkg::ADDR_FIFO_CHAN_B,
      alarm_offset_pkg::ADDR_CHAN_C,
      alarm_offset_pkg::ADDR_CHAN_D,
      alarm_offset_pkg::ADDR_SYNC_CTRL,
      alarm_offset_pkg::ADDR_IRQ_STATUS,
      alarm_offset_pkg::ADDR_IRQ_MASK,
      alarm_offset_pkg::ADDR_ACTIVE_AB,
      alarm_offset_pkg::ADDR_ACTIVE_CD: hit = 1'b1;
      default:                          hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // register next-state: writes, auto-sync, fifo preset, alarms
  // ----------------------------------------------------------------
  always_comb begin
    logic wa;
    logic wc;
    wa = 1'b0;
    wc = 1'b0;
    mask_nxt    = mask_r;
    reg_a_nxt   = reg_a_r;
    reg_b_nxt   = reg_b_r;
    reg_c_nxt   = reg_c_r;
    reg_d_nxt   = reg_d_r;
    sync_en_nxt = sync_en_r;
    imask_nxt   = imask_r;
    if (wr) begin
      case (paddr)
        alarm_offset_pkg::ADDR_ALARM_MASK:
          mask_nxt = (mask_r & ~wmask) | (pwdata[15:0] & wmask);
        alarm_offset_pkg::ADDR_CHAN_A: begin
          // reserved 15:13 stay zero
          reg_a_nxt = ((reg_a_r & ~wmask) | (pwdata[15:0] & wmask)) & 16'h1FFF;
          wa = 1'b1;
        end
        alarm_offset_pkg::ADDR_FIFO_CHAN_B:
          reg_b_nxt = (reg_b_r & ~wmask) | (pwdata[15:0] & wmask);
        alarm_offset_pkg::ADDR_CHAN_C: begin
          reg_c_nxt = ((reg_c_r & ~wmask) | (pwdata[15:0] & wmask)) & 16'h1FFF;
          wc = 1'b1;
        end
        alarm_offset_pkg::ADDR_CHAN_D:
          reg_d_nxt = ((reg_d_r & ~wmask) | (pwdata[15:0] & wmask)) & 16'h1FFF;
        alarm_offset_pkg::ADDR_SYNC_CTRL:
          if (pstrb[0]) sync_en_nxt = pwdata[0];
        alarm_offset_pkg::ADDR_IRQ_MASK:
          if (pstrb[0]) imask_nxt = pwdata[3:0];
        default: ;
      endcase
    end
    // auto-sync: A and B move together on a channel A write; B alone never
    // touches the active words, so writing B first then A updates both at once
    act_a_nxt = act_a_r;
    act_b_nxt = act_b_r;
    act_c_nxt = act_c_r;
    act_d_nxt = act_d_r;
    if (wa && sync_en_r) begin
      act_a_nxt = reg_a_nxt[12:0];
      act_b_nxt = reg_b_r[12:0];
    end
    if (wc && sync_en_r) begin
      act_c_nxt = reg_c_nxt[12:0];
      act_d_nxt = reg_d_r[12:0];
    end
    // fifo sync loads the preset field into the read pointer
    ptr_nxt = fifo_sync_evt ? reg_b_r[15:13] : ptr_r;
    // status: read of irq status clears it, new events win over the clear
    istat_nxt = istat_r;
    if (rd && paddr == alarm_offset_pkg::ADDR_IRQ_STATUS)
      istat_nxt = 4'h0;
    if (wa && sync_en_r) istat_nxt[alarm_offset_pkg::IRQ_AB_SYNC] = 1'b1;
    if (wc && sync_en_r) istat_nxt[alarm_offset_pkg::IRQ_CD_SYNC] = 1'b1;
    if (|unmasked)       istat_nxt[alarm_offset_pkg::IRQ_ALARM]   = 1'b1;
    if (fifo_sync_evt)   istat_nxt[alarm_offset_pkg::IRQ_FIFO]    = 1'b1;
    // alarm status records every used source, masked or not, until the read
    astat_nxt = astat_r;
    if (rd && paddr == alarm_offset_pkg::ADDR_ALARM_MASK)
      astat_nxt = 16'h0000;
    astat_nxt = astat_nxt | (alarm_raw & alarm_offset_pkg::ALARM_USED);
    comb_nxt  = |unmasked;
    irq_nxt   = |(istat_nxt & imask_r);
  end

  // ----------------------------------------------------------------
  // read data and bus answer
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    ready_nxt = acc;
    err_nxt   = acc & ~hit;
    if (rd) begin
      case (paddr)
        // high half shows the sticky alarm status, low half the mask
        alarm_offset_pkg::ADDR_ALARM_MASK:  rdata_nxt = {astat_r, mask_r};
        alarm_offset_pkg::ADDR_CHAN_A:      rdata_nxt = {16'h0000, reg_a_r};
        alarm_offset_pkg::ADDR_FIFO_CHAN_B: rdata_nxt = {16'h0000, reg_b_r};
        alarm_offset_pkg::ADDR_CHAN_C:      rdata_nxt = {16'h0000, reg_c_r};
        alarm_offset_pkg::ADDR_CHAN_D:      rdata_nxt = {16'h0000, reg_d_r};
        alarm_offset_pkg::ADDR_SYNC_CTRL:   rdata_nxt = {31'h0, sync_en_r};
        alarm_offset_pkg::ADDR_IRQ_STATUS:  rdata_nxt = {28'h0, istat_r};
        alarm_offset_pkg::ADDR_IRQ_MASK:    rdata_nxt = {28'h0, imask_r};
        alarm_offset_pkg::ADDR_ACTIVE_AB:
          rdata_nxt = {3'h0, act_b_r, 3'h0, act_a_r};
        alarm_offset_pkg::ADDR_ACTIVE_CD:
          rdata_nxt = {3'h0, act_d_r, 3'h0, act_c_r};
        default:                            rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sample path: shutdown alarm forces mid-scale on every channel
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      if (alarm_raw[alarm_offset_pkg::BIT_OUTPUT_SHUTDOWN])
        samp_nxt[i*16 +: 16] = alarm_offset_pkg::MID_SCALE;
      else
        samp_nxt[i*16 +: 16] = sample_in[i*16 +: 16];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r    <= alarm_offset_pkg::RST_ALARM_MASK;
      reg_a_r   <= alarm_offset_pkg::RST_CHAN_A;
      reg_b_r   <= alarm_offset_pkg::RST_FIFO_CHAN_B;
      reg_c_r   <= alarm_offset_pkg::RST_CHAN_C;
      reg_d_r   <= alarm_offset_pkg::RST_CHAN_D;
      act_a_r   <= 13'h0000;
      act_b_r   <= 13'h0000;
      act_c_r   <= 13'h0000;
      act_d_r   <= 13'h0000;
      sync_en_r <= alarm_offset_pkg::RST_SYNC_CTRL[0];
      astat_r   <= 16'h0000;
      ptr_r     <= alarm_offset_pkg::RST_FIFO_CHAN_B[15:13];
      istat_r   <= 4'h0;
      imask_r   <= alarm_offset_pkg::RST_IRQ_MASK;
      rdata_r   <= 32'h0000_0000;
      ready_r   <= 1'b0;
      err_r     <= 1'b0;
      comb_r    <= 1'b0;
      irq_r     <= 1'b0;
      samp_r    <= '0;
    end else begin
      mask_r    <= mask_nxt;
      reg_a_r   <= reg_a_nxt;
      reg_b_r   <= reg_b_nxt;
      reg_c_r   <= reg_c_nxt;
      reg_d_r   <= reg_d_nxt;
      act_a_r   <= act_a_nxt;
      act_b_r   <= act_b_nxt;
      act_c_r   <= act_c_nxt;
      act_d_r   <= act_d_nxt;
      sync_en_r <= sync_en_nxt;
      astat_r   <= astat_nxt;
      ptr_r     <= ptr_nxt;
      istat_r   <= istat_nxt;
      imask_r   <= imask_nxt;
      rdata_r   <= rdata_nxt;
      ready_r   <= ready_nxt;
      err_r     <= err_nxt;
      comb_r    <= comb_nxt;
      irq_r     <= irq_nxt;
      samp_r    <= samp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign prdata               = rdata_r;
  assign pready               = ready_r;
  assign pslverr              = err_r;
  assign fifo_rd_ptr          = ptr_r;
  assign chan_a_dc_correction = act_a_r;
  assign chan_b_dc_correction = act_b_r;
  assign chan_c_dc_correction = act_c_r;
  assign chan_d_dc_correction = act_d_r;
  assign alarm_combined       = comb_r;
  assign irq                  = irq_r;
  assign sample_out           = samp_r;
endmodule // alarm_mask_offset_sync_regs

// ---- alarm_offset_pkg.sv ----
/*
  package for the alarm mask / offset correction / fifo preset register bank.
  holds register indices, byte addresses, field positions, reset values.
  assumes a 32-bit apb slave with one aligned word per register.
*/
package alarm_offset_pkg;
  // ----------------------------------------------------------------
  // register indices (printed offsets) and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_ALARM_MASK  = 8'h07;
  localparam logic [7:0]  IDX_CHAN_A      = 8'h08;
  localparam logic [7:0]  IDX_FIFO_CHAN_B = 8'h09;
  localparam logic [7:0]  IDX_CHAN_C      = 8'h0A;
  localparam logic [7:0]  IDX_CHAN_D      = 8'h0B;
  localparam logic [7:0]  IDX_SYNC_CTRL   = 8'h20;
  localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h21;
  localparam logic [7:0]  IDX_IRQ_MASK    = 8'h22;
  localparam logic [7:0]  IDX_ACTIVE_AB   = 8'h23;
  localparam logic [7:0]  IDX_ACTIVE_CD   = 8'h24;
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] ADDR_ALARM_MASK  = {2'h0, IDX_ALARM_MASK, 2'h0};
  localparam logic [11:0] ADDR_CHAN_A      = {2'h0, IDX_CHAN_A, 2'h0};
  localparam logic [11:0] ADDR_FIFO_CHAN_B = {2'h0, IDX_FIFO_CHAN_B, 2'h0};
  localparam logic [11:0] ADDR_CHAN_C      = {2'h0, IDX_CHAN_C, 2'h0};
  localparam logic [11:0] ADDR_CHAN_D      = {2'h0, IDX_CHAN_D, 2'h0};
  localparam logic [11:0] ADDR_SYNC_CTRL   = {2'h0, IDX_SYNC_CTRL, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS  = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK    = {2'h0, IDX_IRQ_MASK, 2'h0};
  localparam logic [11:0] ADDR_ACTIVE_AB   = {2'h0, IDX_ACTIVE_AB, 2'h0};
  localparam logic [11:0] ADDR_ACTIVE_CD   = {2'h0, IDX_ACTIVE_CD, 2'h0};
  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int OFS_W       = 13;   // offset word, bits 12:0
  localparam int FIFO_PRE_LO = 13;   // fifo preset, bits 15:13
  localparam int FIFO_PRE_W  = 3;
  localparam int ALARM_W     = 16;
  localparam logic [15:0] ALARM_USED = 16'hBFBC; // bits 14,6,1,0 unused
  localparam int BIT_OUTPUT_SHUTDOWN = 8;
  // irq status bits
  localparam int IRQ_AB_SYNC  = 0;
  localparam int IRQ_CD_SYNC  = 1;
  localparam int IRQ_ALARM    = 2;
  localparam int IRQ_FIFO     = 3;
  localparam int IRQ_W        = 4;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_ALARM_MASK  = 16'hFFFF;
  localparam logic [15:0] RST_CHAN_A      = 16'h0000;
  localparam logic [15:0] RST_FIFO_CHAN_B = 16'h8000;
  localparam logic [15:0] RST_CHAN_C      = 16'h0000;
  localparam logic [15:0] RST_CHAN_D      = 16'h0000;
  localparam logic [15:0] MID_SCALE       = 16'h8000;
  localparam logic [31:0] RST_SYNC_CTRL   = 32'h0000_0001;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;
endpackage

// ---- alarm_offset_properties.sv ----
/*
  concurrent checks on the alarm / offset / fifo preset register bank ports.
  assumes one pclk domain, presetn async active low, bound from the testbench top file.
*/
`timescale 1ns/1ps
module alarm_offset_properties #(
  parameter int NCH = 4                       // converter channels
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [15:0]        alarm_raw,
  input wire logic               fifo_sync_evt,
  input wire logic [NCH*16-1:0]  sample_in,
  input wire logic [NCH*16-1:0]  sample_out,
  input wire logic [2:0]         fifo_rd_ptr,
  input wire logic [12:0]        chan_a_dc_correction,
  input wire logic [12:0]        chan_b_dc_correction,
  input wire logic [12:0]        chan_c_dc_correction,
  input wire logic [12:0]        chan_d_dc_correction,
  input wire logic               alarm_combined
);
  // ----------------------------------------------------------------
  // access steps
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase still waiting for its answer
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  // write access to one register
  sequence wr_s(logic [11:0] a);
    psel && penable && !pready && pwrite && paddr == a;
  endsequence
  // request addressed to channel a; kept as a plain signal so that $past
  // below looks back at one net rather than at an expression
  logic a_wr;
  assign a_wr = psel && pwrite && paddr == alarm_offset_pkg::ADDR_CHAN_A;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  ready_latency_a: assert property (acc_s |=> pready) else $error("no answer one cycle after access");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  refused_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  shutdown_mid_a: assert property (alarm_raw[alarm_offset_pkg::BIT_OUTPUT_SHUTDOWN] |=>
    sample_out == {NCH{alarm_offset_pkg::MID_SCALE}}) else $error("no mid-scale in shutdown");
  pass_through_a: assert property (!alarm_raw[alarm_offset_pkg::BIT_OUTPUT_SHUTDOWN] |=>
    sample_out == $past(sample_in)) else $error("samples not passed");
  ptr_hold_a: assert property (!fifo_sync_evt |=> $stable(fifo_rd_ptr))
    else $error("read pointer moved without sync");
  b_shadow_a: assert property (wr_s(alarm_offset_pkg::ADDR_FIFO_CHAN_B) |=>
    $stable(chan_a_dc_correction) && $stable(chan_b_dc_correction)) else $error("b write applied");
  d_shadow_a: assert property (wr_s(alarm_offset_pkg::ADDR_CHAN_D) |=>
    $stable(chan_c_dc_correction) && $stable(chan_d_dc_correction)) else $error("d write applied");
  unused_quiet_a: assert property ((alarm_raw & alarm_offset_pkg::ALARM_USED) == 16'h0 |=>
    !alarm_combined) else $error("combined alarm from unused source");
  b_cause_a: assert property ($changed(chan_b_dc_correction) |->
    $past(a_wr) || $past(a_wr, 2))
    else $error("b active changed without a write");
endmodule // alarm_offset_properties

// ---- tb.sv ----
/*
  self-checking bench for the alarm / offset / fifo preset register bank.
  assumes the design answers apb one cycle after the first access edge.
*/
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct { logic wr; logic [11:0] a; logic [31:0] d; logic e; } row_t;
  logic        pclk, presetn, psel, penable, pwrite, pslverr, pready, fifo_sync_evt;
  logic        alarm_combined, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [15:0] alarm_raw;
  logic [63:0] sample_in, sample_out;
  logic [2:0]  fifo_rd_ptr;
  logic [12:0] ca, cb, cc, cd;
  logic        er;
  int          failures, check_count;
  // reads carry expected data in d, writes carry write data
  row_t rows[15] = '{
    '{0, alarm_offset_pkg::ADDR_ALARM_MASK, 32'h0000FFFF, 0},
    '{0, alarm_offset_pkg::ADDR_FIFO_CHAN_B, 32'h00008000, 0},
    '{0, alarm_offset_pkg::ADDR_CHAN_A, 32'h00000000, 0},
    '{0, alarm_offset_pkg::ADDR_CHAN_C, 32'h00000000, 0},
    '{1, alarm_offset_pkg::ADDR_FIFO_CHAN_B, 32'h0000A123, 0},
    '{0, alarm_offset_pkg::ADDR_ACTIVE_AB, 32'h00000000, 0},
    '{1, alarm_offset_pkg::ADDR_CHAN_A, 32'h0000FFFF, 0},
    '{0, alarm_offset_pkg::ADDR_CHAN_A, 32'h00001FFF, 0},
    '{0, alarm_offset_pkg::ADDR_ACTIVE_AB, 32'h01231FFF, 0},
    '{1, alarm_offset_pkg::ADDR_CHAN_D, 32'h00000456, 0},
    '{0, alarm_offset_pkg::ADDR_ACTIVE_CD, 32'h00000000, 0},
    '{1, alarm_offset_pkg::ADDR_CHAN_C, 32'h00000789, 0},
    '{0, alarm_offset_pkg::ADDR_ACTIVE_CD, 32'h04560789, 0},
    '{0, 12'hFFC, 32'h00000000, 1},
    '{1, 12'h000, 32'h0000FFFF, 1}};
  alarm_mask_offset_sync_regs #(.NCH(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .alarm_raw(alarm_raw),
    .fifo_sync_evt(fifo_sync_evt), .sample_in(sample_in), .sample_out(sample_out),
    .fifo_rd_ptr(fifo_rd_ptr), .chan_a_dc_correction(ca), .chan_b_dc_correction(cb),
    .chan_c_dc_correction(cc), .chan_d_dc_correction(cd), .alarm_combined(alarm_combined),
    .irq(irq));
  always #5 pclk = ~pclk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic results();
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      $display("CHECK FAILED %0t apb hang", $time);
      results();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x, "read data");
  endtask
  task automatic pulse_sync();
    @(posedge pclk);
    fifo_sync_evt <= 1'b1;
    @(posedge pclk);
    fifo_sync_evt <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 12'h000;
    pwdata = 32'h0; pstrb = 4'hF; alarm_raw = 16'h0000; fifo_sync_evt = 0;
    sample_in = 64'h0; failures = 0; check_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      chk(er, rows[i].e, "slave error flag");
      if (!rows[i].wr) chk(rd, rows[i].d, "table read");
    end
    chk({ca, cb, cc, cd}, {13'h1FFF, 13'h0123, 13'h0789, 13'h0456}, "active ports");
    apb(1'b1, alarm_offset_pkg::ADDR_SYNC_CTRL, 32'h0);
    apb(1'b1, alarm_offset_pkg::ADDR_CHAN_A, 32'h00000AAA);
    rdchk(alarm_offset_pkg::ADDR_ACTIVE_AB, 32'h01231FFF);
    apb(1'b1, alarm_offset_pkg::ADDR_SYNC_CTRL, 32'h1);
    pulse_sync();
    chk(fifo_rd_ptr, 3'b101, "fifo preset");
    sample_in <= 64'h1111_2222_3333_4444; alarm_raw <= 16'h0100;
    repeat (3) @(posedge pclk);
    chk(sample_out, 64'h8000_8000_8000_8000, "mid-scale");
    alarm_raw <= 16'h0010;
    repeat (3) @(posedge pclk);
    chk(sample_out, 64'h1111_2222_3333_4444, "samples");
    chk(alarm_combined, 1'b0, "masked alarm");
    apb(1'b1, alarm_offset_pkg::ADDR_ALARM_MASK, 32'h0000FFEF);
    repeat (2) @(posedge pclk);
    chk(alarm_combined, 1'b1, "unmasked alarm");
    rdchk(alarm_offset_pkg::ADDR_ALARM_MASK, 32'h0110FFEF);
    rdchk(alarm_offset_pkg::ADDR_ALARM_MASK, 32'h0010FFEF);
    alarm_raw <= 16'h4043;
    apb(1'b1, alarm_offset_pkg::ADDR_ALARM_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk(alarm_combined, 1'b0, "unused sources");
    alarm_raw <= 16'h0000;
    apb(1'b0, alarm_offset_pkg::ADDR_IRQ_STATUS, 32'h0);
    apb(1'b1, alarm_offset_pkg::ADDR_IRQ_MASK, 32'h8);
    apb(1'b1, alarm_offset_pkg::ADDR_CHAN_A, 32'h00000001);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0, "masked irq");
    pulse_sync();
    @(posedge pclk);
    chk(irq, 1'b1, "irq raised");
    rdchk(alarm_offset_pkg::ADDR_IRQ_STATUS, 32'h9);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0, "irq cleared");
    presetn <= 1'b0;
    @(posedge pclk);
    chk({fifo_rd_ptr, ca}, {3'b100, 13'h0}, "mid-run reset");
    presetn <= 1'b1;
    rdchk(alarm_offset_pkg::ADDR_FIFO_CHAN_B, 32'h00008000);
    // low byte lane only: bits 15:8 keep their reset value
    pstrb <= 4'h1;
    apb(1'b1, alarm_offset_pkg::ADDR_CHAN_D, 32'h0000FFFF);
    pstrb <= 4'hF;
    rdchk(alarm_offset_pkg::ADDR_CHAN_D, 32'h000000FF);
    chk(cd, 13'h0000, "d write applied");
    results();
  end
endmodule // tb
bind alarm_mask_offset_sync_regs alarm_offset_properties #(.NCH(NCH)) props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .alarm_raw(alarm_raw),
  .fifo_sync_evt(fifo_sync_evt), .sample_in(sample_in), .sample_out(sample_out),
  .fifo_rd_ptr(fifo_rd_ptr), .chan_a_dc_correction(chan_a_dc_correction),
  .chan_b_dc_correction(chan_b_dc_correction), .chan_c_dc_correction(chan_c_dc_correction),
  .chan_d_dc_correction(chan_d_dc_correction), .alarm_combined(alarm_combined));
